// File: tsfr_ramp.v
// Chosen here: the AHB-Lite interface to the registers.
`include "tsfr_regs.vh"

// Summary of operation
// - Segment A 30-bit step added per tick.
// - Segment B 30-bit step added per tick.
// - Segment A tick one or two cycles.
// - Segment B tick one or two cycles.
// - Sixteen-bit length per segment ends it in auto mode.
// - Auto mode clears accumulation entering B.
// - After A go to A or B.
// - After B go to A or B.
// - Segment A end: timeout, trigger A, B.
// - Segment B end: timeout, trigger A, B.
// - Mode bit picks automatic or manual ramping.
// - Delay count and scale set calibration hold.
// - Triggers decode pin edges or always.
// - Auto mode clears accumulation entering A.
module tsfr_ramp (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        sweep_clock_pin,
  input  wire        sweep_direction_pin,
  output reg  [31:0] num_offset,
  output reg         active_seg,
  output reg         ramp_running,
  output reg         cal_hold
);

  reg  [15:0] cfg_q [0:`TSFR_NSLOT-1];  // Configuration words.
  reg         run_en_q;                 // Software ramp enable.
  reg         wr_pend_q;                // Write data phase pending.
  reg  [7:0]  wr_idx_q;                 // Index of the pending write.
  reg         clk_prev_q;               // Previous sweep clock level.
  reg         dir_prev_q;               // Previous direction level.
  reg  [29:0] step_q;                   // Step of the running segment.
  reg  [15:0] len_q;                    // Length of the running segment.
  reg         dbl_q;                    // Double clock of the running segment.
  reg  [15:0] cnt_q;                    // Ticks spent in the segment.
  reg         half_q;                   // Phase within a doubled tick.
  reg  [16:0] cal_cnt_q;                // Calibration hold countdown.
  reg  [31:0] rd_d;                     // Read word for an address phase.
  wire [7:0]  a_idx = haddr[9:2];       // Index of the address phase.
  wire        a_ok  = hsel & htrans[1] & hready;
  wire        a_map = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
  // An address phase is taken when the slave is selected, the transfer is
  // NONSEQ or SEQ and the previous data phase has completed on the bus.
  // Only word-aligned addresses in the lowest kilobyte reach a register;
  // anything else reads back zero and drops its write data, still OKAY.

  // Maps a register index to its storage slot, or 4'hF if none.
  function [3:0] slot_of;
    input [7:0] idx;
    begin
      // The eight consecutive words from the segment A high step up to the
      // mode word occupy slots zero to seven in address order.
      if (idx >= `TSFR_IDX_A_STEP_HI && idx <= `TSFR_IDX_MODE) begin
        slot_of = idx[3:0] - 4'h2;
      end else if (idx == `TSFR_IDX_TRIG) begin
        // The trigger word sits just below that run of words.
        slot_of = `TSFR_SLOT_TRIG;
      end else if (idx == `TSFR_IDX_SCALE) begin
        // The scale word sits just above it.
        slot_of = `TSFR_SLOT_SCALE;
      end else begin
        // Status, run and unmapped words have no storage slot.
        slot_of = 4'hF;
      end
    end
  endfunction

  // Decodes one trigger selection against this cycle's pin edges.
  function trig_hit;
    input [3:0] src;
    input       cr;
    input       cf;
    input       dr;
    input       df;
    begin
      // Disabled and unused codes never fire, so a stray code written by
      // software cannot end a segment.
      case (src)
        `TSFR_TRG_CLK_RISE: trig_hit = cr;
        `TSFR_TRG_DIR_RISE: trig_hit = dr;
        `TSFR_TRG_ALWAYS:   trig_hit = 1'b1;
        `TSFR_TRG_CLK_FALL: trig_hit = cf;
        `TSFR_TRG_DIR_FALL: trig_hit = df;
        default:            trig_hit = 1'b0;
      endcase
    end
  endfunction

  // Field views of the configuration words.
  wire [15:0] w_a_hi = cfg_q[0];
  wire [15:0] w_seq  = cfg_q[3];
  wire [15:0] w_b_hi = cfg_q[4];
  wire [15:0] w_mode = cfg_q[`TSFR_SLOT_MODE];
  wire [15:0] w_trig = cfg_q[`TSFR_SLOT_TRIG];
  wire [15:0] w_scl  = cfg_q[`TSFR_SLOT_SCALE];
  wire [29:0] step_a = {w_a_hi[`TSFR_A_HI_MSB:`TSFR_A_HI_LSB], cfg_q[1]};
  wire [29:0] step_b = {w_b_hi[`TSFR_B_HI_MSB:0], cfg_q[5]};
  // High selects pin-driven stepping, low the free-running automatic ramp.
  // manual mode select
  wire        manual = w_mode[`TSFR_MANUAL];

  // Pin edges, taken as synchronous inputs.
  // Each edge lasts exactly one cycle: the cycle in which the pin first
  // shows its new level against the copy held from the previous cycle.
  // The copies reset low, so a pin held high through reset reads as one
  // rising edge on the first cycle after release.
  wire clk_r = sweep_clock_pin & ~clk_prev_q;
  wire clk_f = ~sweep_clock_pin & clk_prev_q;
  wire dir_r = sweep_direction_pin & ~dir_prev_q;
  wire dir_f = ~sweep_direction_pin & dir_prev_q;
  wire trg_a = trig_hit(w_trig[`TSFR_TA_MSB:`TSFR_TA_LSB], clk_r, clk_f, dir_r, dir_f);
  wire trg_b = trig_hit(w_trig[`TSFR_TB_MSB:`TSFR_TB_LSB], clk_r, clk_f, dir_r, dir_f);

  // In automatic mode a doubled segment ticks on every second cycle only,
  // the first tick falling on the second cycle after entry.
  // In manual mode each rising edge of the sweep clock pin is one tick.
  // doubled tick gating
  wire tick = manual ? clk_r : (~dbl_q | half_q);
  // The length counts ticks, so in automatic mode the timeout fires on the tick
  // that would bring the count up to the length; a length of zero ends on the first.
  // length timeout reached
  wire tmo = ~manual & tick & ({1'b0, cnt_q} + 17'h00001 >= {1'b0, len_q});

  // Each segment keeps its end source in a different word: segment A in
  // the sequencing word, segment B in the mode word.
  // running segment end source
  wire [1:0] end_src = active_seg ? w_mode[`TSFR_END_MSB:`TSFR_END_LSB]
                                  : w_seq[`TSFR_END_MSB:`TSFR_END_LSB];
  reg        seg_end;

  // Selects which event ends the running segment.
  always @* begin
    case (end_src)
      `TSFR_END_TIMEOUT: seg_end = tmo;
      `TSFR_END_TRIG_A:  seg_end = trg_a;
      `TSFR_END_TRIG_B:  seg_end = trg_b;
      default:           seg_end = 1'b0;
    endcase
  end

  // A fresh start always enters segment A; otherwise the successor bit of
  // the segment being left picks the next one.
  // The clear applies only in automatic mode and only to the segment that
  // is being entered.
  // successor after the running segment
  wire nxt = active_seg ? w_mode[`TSFR_B_SUCC] : w_seq[`TSFR_A_SUCC];
  wire go  = run_en_q & ~ramp_running;  // Fresh start always enters A.
  wire sw  = ramp_running & run_en_q & seg_end;
  wire tgt = go ? 1'b0 : nxt;           // Segment being entered.
  wire clr = ~manual & (tgt ? w_seq[`TSFR_B_CLR] : w_trig[`TSFR_A_CLR]);
  wire [31:0] step_x = {{2{step_q[29]}}, step_q};

  // Builds the read word for an address phase, bypassing a pending write.
  // The bypass lets a read that follows a write to the same word see the
  // new value, although the storage is only written at the end of the
  // write's data phase.
  always @* begin
    rd_d = 32'h00000000;
    if (a_map && slot_of(a_idx) != 4'hF) begin
      if (wr_pend_q && wr_idx_q == a_idx) begin
        rd_d = {16'h0000, hwdata[15:0]};
      end else begin
        rd_d = {16'h0000, cfg_q[slot_of(a_idx)]};
      end
    end else if (a_map && a_idx == `TSFR_IDX_RUN) begin
      rd_d = {31'h00000000, (wr_pend_q && wr_idx_q == a_idx) ? hwdata[0] : run_en_q};
    end else if (a_map && a_idx == `TSFR_IDX_STATUS) begin
      rd_d = {cnt_q, 13'h0000, cal_hold, active_seg, ramp_running};
    end
  end

  // Bus slave: zero wait states, OKAY always, read data registered.
  // The slave never stretches a transfer, so hreadyout stays high, and
  // hrdata holds its word until the next read address phase is taken.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= a_ok & hwrite & a_map;
      if (a_ok) begin
        wr_idx_q <= a_idx;
      end
      if (a_ok && !hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  // One storage word per slot; software writes steer the sequencer.
  // A word is written at the edge that closes the write's data phase,
  // using the index latched in the address phase.
  genvar gi;
  generate
    for (gi = 0; gi < `TSFR_NSLOT; gi = gi + 1) begin : g_cfg
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cfg_q[gi] <= (gi == `TSFR_SLOT_MODE) ? `TSFR_RST_MODE :
                       (gi == `TSFR_SLOT_SCALE) ? `TSFR_RST_SCALE : `TSFR_RST_ZERO;
        end else if (wr_pend_q && slot_of(wr_idx_q) == gi) begin
          cfg_q[gi] <= hwdata[15:0];
        end
      end
    end
  endgenerate

  // Run enable word.
  // Writing one starts the sequencer in segment A; writing zero stops it
  // and freezes the offset where it stands.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_en_q <= 1'b0;
    end else if (wr_pend_q && wr_idx_q == `TSFR_IDX_RUN) begin
      run_en_q <= hwdata[0];
    end
  end

  // Ramp sequencer: segment changes, ticks and accumulation.
  // A segment change takes effect at the edge on which its end event is
  // seen; the step added at that edge is still the old segment's step.
  // The calibration countdown reloads on every entry and counts down by
  // one each cycle; cal_hold follows it one cycle later.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Reset parks the sequencer idle in segment A with a zero offset.
      clk_prev_q   <= 1'b0;
      dir_prev_q   <= 1'b0;
      ramp_running <= 1'b0;
      active_seg   <= 1'b0;
      step_q       <= 30'h00000000;
      len_q        <= 16'h0000;
      dbl_q        <= 1'b0;
      cnt_q        <= 16'h0000;
      half_q       <= 1'b0;
      cal_cnt_q    <= 17'h00000;
      cal_hold     <= 1'b0;
      num_offset   <= 32'h00000000;
    end else begin
      clk_prev_q <= sweep_clock_pin;
      dir_prev_q <= sweep_direction_pin;
      cal_hold   <= (cal_cnt_q != 17'h00000);
      if (cal_cnt_q != 17'h00000) begin
        cal_cnt_q <= cal_cnt_q - 17'h00001;
      end
      if (!run_en_q) begin
        // Stopping holds the offset where it stands.
        ramp_running <= 1'b0;
      end else if (go || sw) begin
        ramp_running <= 1'b1;
        active_seg   <= tgt;
        step_q       <= tgt ? step_b : step_a;
        len_q        <= tgt ? cfg_q[6] : cfg_q[2];
        dbl_q        <= tgt ? w_seq[`TSFR_B_DBL] : w_a_hi[`TSFR_A_DBL];
        cnt_q        <= 16'h0000;
        half_q       <= 1'b0;
        cal_cnt_q    <= {7'h00, w_mode[`TSFR_DLY_MSB:`TSFR_DLY_LSB]} << w_scl[`TSFR_SCALE_MSB:0];
        // A fresh start or an enabled clear begins the segment from zero.
        if (go || clr) begin
          num_offset <= 32'h00000000;
        end else if (tick) begin
          num_offset <= num_offset + step_x;
        end
      end else begin
        // Toggle the doubled-tick phase on every cycle inside a segment.
        half_q <= ~half_q;
        if (tick) begin
          num_offset <= num_offset + step_x;
          cnt_q      <= cnt_q + 16'h0001;
        end
      end
    end
  end

endmodule

// File: tsfr_regs.vh
`ifndef TSFR_REGS_VH
`define TSFR_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define TSFR_IDX_TRIG       8'h61
`define TSFR_IDX_A_STEP_HI  8'h62
`define TSFR_IDX_A_STEP_LO  8'h63
`define TSFR_IDX_A_LEN      8'h64
`define TSFR_IDX_SEQ        8'h65
`define TSFR_IDX_B_STEP_HI  8'h66
`define TSFR_IDX_B_STEP_LO  8'h67
`define TSFR_IDX_B_LEN      8'h68
`define TSFR_IDX_MODE       8'h69
`define TSFR_IDX_SCALE      8'h6A
`define TSFR_IDX_STATUS     8'h7E
`define TSFR_IDX_RUN        8'h7F

// Storage slots of the sixteen-bit configuration words.
`define TSFR_NSLOT          10
`define TSFR_SLOT_TRIG      4'h8
`define TSFR_SLOT_SCALE     4'h9
`define TSFR_SLOT_MODE      4'h7

// Reset values.
`define TSFR_RST_MODE       16'h4440
`define TSFR_RST_SCALE      16'h0007
`define TSFR_RST_ZERO       16'h0000

// Field positions.
`define TSFR_A_HI_MSB       15
`define TSFR_A_HI_LSB       2
`define TSFR_A_DBL          0
`define TSFR_B_DBL          6
`define TSFR_B_CLR          5
`define TSFR_A_SUCC         4
`define TSFR_B_SUCC         4
`define TSFR_END_MSB        1
`define TSFR_END_LSB        0
`define TSFR_B_HI_MSB       13
`define TSFR_MANUAL         5
`define TSFR_DLY_MSB        15
`define TSFR_DLY_LSB        6
`define TSFR_A_CLR          15
`define TSFR_TB_MSB         10
`define TSFR_TB_LSB         7
`define TSFR_TA_MSB         6
`define TSFR_TA_LSB         3
`define TSFR_SCALE_MSB      2

// Segment end sources.
`define TSFR_END_TIMEOUT    2'h0
`define TSFR_END_TRIG_A     2'h1
`define TSFR_END_TRIG_B     2'h2

// Trigger encodings.
`define TSFR_TRG_CLK_RISE   4'h1
`define TSFR_TRG_DIR_RISE   4'h2
`define TSFR_TRG_ALWAYS     4'h4
`define TSFR_TRG_CLK_FALL   4'h9
`define TSFR_TRG_DIR_FALL   4'hA

`endif

// File: tsfr_ramp_assertions.sv
module tsfr_ramp_assertions (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        sweep_clock_pin,
  input wire [31:0] num_offset,
  input wire        active_seg,
  input wire        ramp_running,
  input wire        cal_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] ra_q;  // Index of the last address phase taken.
  reg       rv_q;  // A read data phase is under way.
  reg       wv_q;  // A write data phase is under way.
  reg       man_q; // Shadow of the manual ramping bit.
  // Follow the bus so that reads and the mode bit are known here.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ra_q <= 8'h00;
      rv_q <= 1'b0;
      wv_q <= 1'b0;
      man_q <= 1'b0;
    end else begin
      if (wv_q && ra_q == 8'h69) man_q <= hwdata[5];
      rv_q <= hsel && htrans[1] && hready && !hwrite;
      wv_q <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready) ra_q <= haddr[9:2];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_start;
    $rose(ramp_running);
  endsequence
  sequence s_quiet;
    !sweep_clock_pin [*3];
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_first_seg: assert property (s_start |-> !active_seg && num_offset == 32'h0)
    else $error("run did not start in segment A at zero");
  a_cal_start: assert property (s_start |-> ##[0:2] cal_hold)
    else $error("calibration hold missing at start");
  a_manual_hold: assert property (s_quiet ##0 (man_q && $past(man_q) && ramp_running
    && $past(ramp_running)) |-> $stable(num_offset)) else $error("manual offset moved");
  a_read_upper: assert property (rv_q && ra_q != 8'h7E |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_run_status: assert property (rv_q && ra_q == 8'h7E |-> hrdata[0] == $past(ramp_running))
    else $error("status run bit wrong");
  a_reset_clear: assert property (!$past(hresetn) |-> !ramp_running && num_offset == 32'h0)
    else $error("outputs not cleared after reset");
endmodule

bind tsfr_ramp tsfr_ramp_assertions i_tsfr_ramp_assertions (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .sweep_clock_pin(sweep_clock_pin), .num_offset(num_offset), .active_seg(active_seg),
  .ramp_running(ramp_running), .cal_hold(cal_hold));

// File: two_segment_frequency_ramp_bench.sv
module two_segment_frequency_ramp_bench;
  timeunit 1ns;
  timeprecision 1ps;
  reg         hclk, hresetn, hsel, hwrite, ck, dr;
  reg  [1:0]  htrans;
  reg  [31:0] haddr, hwdata, d;
  wire [31:0] hrdata, ofs;
  wire        rdy, resp, seg, run, cal;
  integer     errors, total_checks, i, j;
  tsfr_ramp i_tsfr_ramp (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
    .hrdata(hrdata), .hreadyout(rdy), .hresp(resp), .sweep_clock_pin(ck),
    .sweep_direction_pin(dr), .num_offset(ofs), .active_seg(seg), .ramp_running(run),
    .cal_hold(cal));
  // One single AHB transfer; read data lands in d.
  task xfer(input [7:0] idx, input w, input [15:0] wd);
    begin
      @(posedge hclk);
      haddr <= {22'h000000, idx, 2'h0};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (rdy !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= {16'h0000, wd};
      @(posedge hclk);
      while (rdy !== 1'b1) @(posedge hclk);
      d = hrdata;
    end
  endtask
  // Writable bits of each word; reserved bits are always written as zero.
  function [15:0] legal(input [7:0] x);
    case (x)
      8'h62:   legal = 16'hFFFD;
      8'h65:   legal = 16'h0073;
      8'h66:   legal = 16'h3FFF;
      default: legal = 16'hFFFF;
    endcase
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task results;
    begin
      $display("errors=%0d checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Start the sequencer and return just after its first segment entry.
  task go;
    begin
      xfer(8'h7F, 1'b1, 16'h0001);
      @(negedge hclk);
      while (run !== 1'b1) @(negedge hclk);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge hclk);
  endtask
  // Pins change just after a rising edge, then settle for three cycles.
  task pin(input c, input r);
    begin
      @(posedge hclk);
      ck <= c;
      dr <= r;
      cyc(3);
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    #40000;
    errors = errors + 1;
    results;
  end
  initial begin
    {hresetn, hwrite, ck, dr, htrans, haddr, hwdata} = 0;
    hsel = 1'b1;
    errors = 0;
    total_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, then write and read back words 8'h62 to 8'h68, with an unmapped hole.
    for (i = 8'h62; i <= 8'h6A; i = i + 1) begin
      xfer(i[7:0], 1'b0, 16'h0000);
      chk(d, i == 8'h69 ? 32'h4440 : (i == 8'h6A ? 32'h0007 : 32'h0));
    end
    for (i = 8'h62; i <= 8'h68; i = i + 1) begin
      xfer(i[7:0], 1'b1, (16'hA5C3 ^ i[15:0]) & legal(i[7:0]));
    end
    xfer(8'h10, 1'b1, 16'hFFFF);
    for (i = 8'h62; i <= 8'h68; i = i + 1) begin
      xfer(i[7:0], 1'b0, 16'h0000);
      chk(d, {16'h0000, (16'hA5C3 ^ i[15:0]) & legal(i[7:0])});
    end
    xfer(8'h10, 1'b0, 16'h0000);
    chk(d, 32'h0);
    // Segment A alone, step minus three, length two, single then double clock.
    xfer(8'h61, 1'b1, 16'h0000);
    xfer(8'h63, 1'b1, 16'hFFFD);
    xfer(8'h64, 1'b1, 16'h0002);
    xfer(8'h65, 1'b1, 16'h0000);
    xfer(8'h69, 1'b1, 16'h4440);
    for (j = 0; j < 2; j = j + 1) begin
      xfer(8'h62, 1'b1, 16'hFFFC | j[15:0]);
      go;
      for (i = 1; i < 5; i = i + 1) begin
        cyc(1);
        chk(ofs, 32'h0 - 3 * (j == 1 ? i / 2 : i));
      end
      chk({31'h0, seg}, 32'h0);
      chk({31'h0, cal}, 32'h1);
      xfer(8'h7F, 1'b1, 16'h0000);
    end
    // A to B with B clear, B back to A with and without the A clear.
    xfer(8'h62, 1'b1, 16'hFFFC);
    xfer(8'h65, 1'b1, 16'h0030);
    xfer(8'h66, 1'b1, 16'h0000);
    xfer(8'h67, 1'b1, 16'h0005);
    xfer(8'h68, 1'b1, 16'h0003);
    for (j = 0; j < 2; j = j + 1) begin
      xfer(8'h61, 1'b1, j == 1 ? 16'h8000 : 16'h0000);
      go;
      cyc(2);
      chk({seg, ofs}, {1'b1, 32'h0});
      cyc(2);
      chk({seg, ofs}, {1'b1, 32'd10});
      cyc(1);
      chk({seg, ofs}, {1'b0, j == 1 ? 32'h0 : 32'd15});
      xfer(8'h7F, 1'b1, 16'h0000);
    end
    // Segment B on a doubled clock: one tick every second cycle, then back to A.
    xfer(8'h61, 1'b1, 16'h0000);
    xfer(8'h65, 1'b1, 16'h0070);
    go;
    cyc(4);
    chk({seg, ofs}, {1'b1, 32'd5});
    cyc(3);
    chk({seg, ofs}, {1'b1, 32'd10});
    cyc(1);
    chk({seg, ofs}, {1'b0, 32'd15});
    xfer(8'h7F, 1'b1, 16'h0000);
    // Manual ramping: A ends on clock pin fall, B on direction pin rise.
    xfer(8'h61, 1'b1, 16'h0148);
    xfer(8'h64, 1'b1, 16'h0001);
    xfer(8'h68, 1'b1, 16'h0001);
    xfer(8'h65, 1'b1, 16'h0010);
    xfer(8'h69, 1'b1, 16'h4462);
    go;
    cyc(4);
    chk({seg, ofs}, 33'h0);
    pin(1'b1, 1'b0);
    chk({seg, ofs}, {1'b0, 32'hFFFFFFFD});
    xfer(8'h65, 1'b1, 16'h0011);
    pin(1'b0, 1'b0);
    chk({31'h0, seg}, 32'h1);
    pin(1'b1, 1'b0);
    chk(ofs, 32'h2);
    pin(1'b1, 1'b1);
    chk({31'h0, seg}, 32'h0);
    xfer(8'h7E, 1'b0, 16'h0000);
    chk(d, 32'h5);
    results;
  end
endmodule
